//--- hdl/iad_pkg.sv
// package for the i/o hub address decoder: offsets, fields, encodings
package iad_pkg;
   localparam int NUM_PORTS = 4;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_VGA_EN   = 8'h04;
   localparam logic [7:0] REG_LOW_TOP  = 8'h08;
   localparam logic [7:0] REG_HIGH_TOP = 8'h0C;
   localparam logic [7:0] REG_NC_BASE  = 8'h10;
   localparam logic [7:0] REG_NC_LIMIT = 8'h14;
   localparam logic [7:0] REG_IN_BASE  = 8'h18;
   localparam logic [7:0] REG_IN_LIMIT = 8'h1C;
   localparam logic [7:0] REG_POP_TOP  = 8'h20;
   localparam logic [7:0] REG_AP_BASE  = 8'h24;
   localparam logic [7:0] REG_AP_LIMIT = 8'h28;
   localparam logic [7:0] REG_STATUS   = 8'h2C;
   localparam logic [7:0] REG_PBASE0   = 8'h30;
   localparam logic [7:0] REG_PLIM0    = 8'h40;
   // ctrl fields and the link source bit range of the address
   localparam int CTRL_DEBUG_BIT = 0;
   localparam int CTRL_GFX_BIT   = 1;
   localparam int SRC_LSB        = 30;
   localparam int SRC_MSB        = 35;
   // status fields
   localparam int ST_MEM_ERR = 0;
   localparam int ST_IO_ERR  = 1;
   localparam int ST_AP_ERR  = 2;
   // range registers hold address bits 35:20 (1 MB granules)
   localparam int GRAN_LSB = 20;
   localparam logic [15:0] LOW_TOP_RST  = 16'h0000;
   localparam logic [15:0] HIGH_TOP_RST = 16'h0000;
   localparam logic [15:0] PHYS_TOP_RST = 16'hFFFF;
   // fixed map
   localparam logic [63:0] BASE_DRAM_TOP = 64'h0000_0000_0009_FFFF;
   localparam logic [63:0] ONE_MB    = 64'h0000_0000_0010_0000;
   localparam logic [63:0] FOUR_GB   = 64'h0000_0001_0000_0000;
   localparam logic [63:0] EIGHT_GB  = 64'h0000_0002_0000_0000;
   localparam logic [63:0] VGA_LO    = 64'h0000_0000_000A_0000;
   localparam logic [63:0] VGA_HI    = 64'h0000_0000_000B_FFFF;
   localparam logic [63:0] PHYS_LIM  = 64'h0000_0100_0000_0000;
   localparam logic [31:0] IO_LIMIT  = 32'h0001_0000;
   // request kinds
   typedef enum logic [1:0] {
      IAD_MEM = 2'b00,
      IAD_IO  = 2'b01,
      IAD_CFG = 2'b10
   } iad_kind_t;
   // destinations
   typedef enum logic [2:0] {
      IAD_DST_NONE  = 3'b000,
      IAD_DST_DRAM  = 3'b001,
      IAD_DST_PORT  = 3'b010,
      IAD_DST_HUB   = 3'b011,
      IAD_DST_ABORT = 3'b100,
      IAD_DST_ERR   = 3'b101
   } iad_dest_t;
endpackage

//--- hdl/iad_decoder.sv
// i/o hub target address decoder with axi4-lite range registers
// Summary of operation
// [RULE1] link memory addresses are 36 bits; pcie decodes all 64
// [RULE2] inbound memory beyond the link physical top is flagged an error
// [RULE3] requester memory requests never carry address bits 63..40
// [RULE4] full 64-bit compare; positive decode only when bits 63..36 zero
// [RULE5] outbound link i/o decode uses only the low 16 address bits
// [RULE6] inbound 32-bit i/o beyond 64 KB is an error
// [RULE7] requester i/o requests never carry address bits 31..16
// [RULE8] config: 256 buses, 32 devices, 8 functions, a single segment
// [RULE9] debug mode drops link source bits from the forwarding decode
// [RULE10] legacy hub port takes everything not positively decoded
// [RULE11] no address above 8 GB reaches dram
// [RULE12] gfx mode: aperture linear writes only from hub; others unsupported
// [RULE13] low 640 KB, 1 MB to low top, 4 GB to high top are dram
// [RULE14] base/limit window inside dram is non-coherent, rest coherent
// [RULE15] inbound dram by programmable ranges; outbound dram goes subtractive
// [RULE16] vga range goes to vga-forward port, else to the hub port
// [RULE17] software sets vga-forward in at most one root port
// [RULE18] vga range always goes to the vga device, also in management mode
// [RULE19] e/f segments not decoded explicitly either direction
// [RULE20] software covers c/d segments with an inbound dram range
// [RULE21] outbound c-f checked against all targets before subtractive
// [RULE22] locked legacy sequences complete; atomicity not guaranteed
// [RULE23] inbound dram window hit without populated dram master aborts
// [RULE24] one destination per request, priority error, vga, ranges, default
// [RULE25] each address error sets a software-visible status flag
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iad_decoder
   import iad_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic        req_valid_i,
   input  wire logic        req_inbound_i,
   input  wire logic [1:0]  req_kind_i,
   input  wire logic        req_write_i,
   input  wire logic        req_lock_i,
   input  wire logic [2:0]  req_src_port_i,
   input  wire logic [63:0] req_addr_i,
   output logic             dec_valid_o,
   output logic [2:0]       dec_dest_o,
   output logic [2:0]       dec_port_o,
   output logic             dec_noncoh_o,
   output logic             dec_lock_o,
   output logic [63:0]      dec_addr_o,
   output logic [7:0]       cfg_bus_o,
   output logic [4:0]       cfg_dev_o,
   output logic [2:0]       cfg_func_o
);
   // hub port number used by inbound requests coming from the legacy hub
   localparam logic [2:0] HUB_SRC = 3'h7;

   logic [1:0]            ctrl;
   logic [NUM_PORTS-1:0]  vga_en;
   logic [15:0]           low_top;
   logic [15:0]           high_top;
   logic [15:0]           nc_base;
   logic [15:0]           nc_limit;
   logic [15:0]           in_base;
   logic [15:0]           in_limit;
   logic [15:0]           pop_top;
   logic [15:0]           ap_base;
   logic [15:0]           ap_limit;
   logic [2:0]            status;
   logic [15:0]           pbase [NUM_PORTS];
   logic [15:0]           plim  [NUM_PORTS];

   // axi write channel: take address and data in either order
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  ws_q;
   logic        wr_go;
   assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
   assign wr_go = aw_held && w_held && !s_axi_bvalid_o;

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= 8'h00;
         w_q     <= 32'h0000_0000;
         ws_q    <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held <= 1'b1;
            aw_q    <= s_axi_awaddr_i;
         end
         else if (wr_go)
            aw_held <= 1'b0;
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held <= 1'b1;
            w_q    <= s_axi_wdata_i;
            ws_q   <= s_axi_wstrb_i;
         end
         else if (wr_go)
            w_held <= 1'b0;
      end
   end

   logic        wr_hit;
   always_comb
   begin
      wr_hit = 1'b1;
      unique case (aw_q)
         REG_CTRL, REG_VGA_EN, REG_LOW_TOP, REG_HIGH_TOP, REG_NC_BASE,
         REG_NC_LIMIT, REG_IN_BASE, REG_IN_LIMIT, REG_POP_TOP,
         REG_AP_BASE, REG_AP_LIMIT, REG_STATUS: wr_hit = 1'b1;
         default: wr_hit = (aw_q >= REG_PBASE0)
                        && (aw_q < REG_PLIM0 + 8'(4 * NUM_PORTS))
                        && (aw_q[1:0] == 2'b00);
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= AXI_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // low half-word write helper honouring byte strobes
   function automatic logic [15:0] upd16(input logic [15:0] old);
      upd16 = old;
      if (ws_q[0])
         upd16[7:0] = w_q[7:0];
      if (ws_q[1])
         upd16[15:8] = w_q[15:8];
   endfunction

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctrl     <= 2'h0;
         vga_en   <= '0;
         low_top  <= LOW_TOP_RST;
         high_top <= HIGH_TOP_RST;
         nc_base  <= 16'hFFFF;
         nc_limit <= 16'h0000;
         in_base  <= 16'h0000;
         in_limit <= 16'h0000;
         pop_top  <= PHYS_TOP_RST;
         ap_base  <= 16'hFFFF;
         ap_limit <= 16'h0000;
      end
      else if (wr_go && ws_q[0])
      begin
         unique case (aw_q)
            REG_CTRL:     ctrl     <= w_q[1:0];
            REG_VGA_EN:   vga_en   <= w_q[NUM_PORTS-1:0]; // RULE17
            REG_LOW_TOP:  low_top  <= upd16(low_top);
            REG_HIGH_TOP: high_top <= upd16(high_top);
            REG_NC_BASE:  nc_base  <= upd16(nc_base);
            REG_NC_LIMIT: nc_limit <= upd16(nc_limit);
            REG_IN_BASE:  in_base  <= upd16(in_base);
            REG_IN_LIMIT: in_limit <= upd16(in_limit);
            REG_POP_TOP:  pop_top  <= upd16(pop_top);
            REG_AP_BASE:  ap_base  <= upd16(ap_base);
            REG_AP_LIMIT: ap_limit <= upd16(ap_limit);
            default:      ;
         endcase
      end
   end

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++)
      begin : g_port
         always_ff @(posedge sys_clk_i or negedge arst_n_i)
         begin
            if (!arst_n_i)
            begin
               pbase[gp] <= 16'hFFFF;
               plim[gp]  <= 16'h0000;
            end
            else if (wr_go && ws_q[0])
            begin
               if (aw_q == REG_PBASE0 + 8'(4 * gp))
                  pbase[gp] <= upd16(pbase[gp]);
               if (aw_q == REG_PLIM0 + 8'(4 * gp))
                  plim[gp] <= upd16(plim[gp]);
            end
         end
      end
   endgenerate

   // axi read channel
   logic [31:0] rd_val;
   logic        rd_hit;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr_i)
         REG_CTRL:     rd_val = {30'h0, ctrl};
         REG_VGA_EN:   rd_val = 32'(vga_en);
         REG_LOW_TOP:  rd_val = {16'h0, low_top};
         REG_HIGH_TOP: rd_val = {16'h0, high_top};
         REG_NC_BASE:  rd_val = {16'h0, nc_base};
         REG_NC_LIMIT: rd_val = {16'h0, nc_limit};
         REG_IN_BASE:  rd_val = {16'h0, in_base};
         REG_IN_LIMIT: rd_val = {16'h0, in_limit};
         REG_POP_TOP:  rd_val = {16'h0, pop_top};
         REG_AP_BASE:  rd_val = {16'h0, ap_base};
         REG_AP_LIMIT: rd_val = {16'h0, ap_limit};
         REG_STATUS:   rd_val = {29'h0, status};
         default:
         begin
            rd_hit = 1'b0;
            for (int i = 0; i < NUM_PORTS; i++)
            begin
               if (s_axi_araddr_i == REG_PBASE0 + 8'(4 * i))
               begin
                  rd_val = {16'h0, pbase[i]};
                  rd_hit = 1'b1;
               end
               if (s_axi_araddr_i == REG_PLIM0 + 8'(4 * i))
               begin
                  rd_val = {16'h0, plim[i]};
                  rd_hit = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= AXI_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= rd_val;
         s_axi_rresp_o  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // decode, single step, fixed priority
   logic [63:0] a;
   logic [63:0] low_top_a;
   logic [63:0] high_top_a;
   logic        in_mem;
   logic        hi_set;
   logic        mem_err;
   logic        io_err;
   logic        ap_err;
   logic        is_dram;
   logic        vga_hit;
   logic [2:0]  vga_port;
   logic        vga_any;
   logic        port_hit;
   logic [2:0]  hit_port;
   logic [2:0]  next_dest;
   logic [2:0]  next_port;
   logic        next_nc;

   function automatic logic [63:0] gaddr(input logic [15:0] g);
      gaddr = {28'h0, g, 20'h0};
   endfunction

   always_comb
   begin
      a = req_addr_i;
      in_mem = req_inbound_i && (req_kind_i == IAD_MEM);
      // raw address, before the link clears bits 63..36
      hi_set = (req_kind_i == IAD_MEM) && |req_addr_i[63:36]; // RULE4
      if (!req_inbound_i)
      begin
         a[63:36] = '0; // RULE1
         if (ctrl[CTRL_DEBUG_BIT])
            a[SRC_MSB:SRC_LSB] = '0; // RULE9
         if (req_kind_i == IAD_IO)
            a[63:16] = '0; // RULE5
      end
      low_top_a = gaddr(low_top);
      high_top_a = gaddr(high_top);
      mem_err = in_mem && (req_addr_i >= PHYS_LIM
                || req_addr_i >= gaddr(pop_top)); // RULE2
      io_err = req_inbound_i && (req_kind_i == IAD_IO)
               && (req_addr_i >= 64'(IO_LIMIT)); // RULE6
      ap_err = ctrl[CTRL_GFX_BIT] && in_mem
               && a >= gaddr(ap_base) && a < gaddr(ap_limit) + ONE_MB
               && !(req_write_i && req_src_port_i == HUB_SRC); // RULE12
      // c-f segments count as dram so inbound shadow reads complete
      // RULE13 RULE11 RULE19
      is_dram = (a <= BASE_DRAM_TOP || (a > VGA_HI && a < ONE_MB)
                 || (a >= ONE_MB && a < low_top_a)
                 || (a >= FOUR_GB && a < high_top_a)) && a < EIGHT_GB;
      vga_hit = (req_kind_i == IAD_MEM) && !hi_set
                && a >= VGA_LO && a <= VGA_HI;
      vga_any = |vga_en;
      vga_port = '0;
      port_hit = 1'b0;
      hit_port = '0;
      for (int i = NUM_PORTS - 1; i >= 0; i--)
      begin
         if (vga_en[i])
            vga_port = 3'(i);
         if (a >= gaddr(pbase[i]) && a < gaddr(plim[i]) + ONE_MB)
         begin
            port_hit = 1'b1; // RULE21
            hit_port = 3'(i);
         end
      end
      next_port = '0;
      next_nc = 1'b0;
      if (mem_err || io_err || ap_err)
         next_dest = IAD_DST_ERR; // RULE24
      else if (req_kind_i == IAD_CFG)
         next_dest = IAD_DST_PORT; // RULE8
      else if (hi_set)
         next_dest = IAD_DST_HUB; // RULE4
      else if (vga_hit)
      begin
         // RULE16 RULE18
         next_dest = vga_any ? IAD_DST_PORT : IAD_DST_HUB;
         next_port = vga_port;
      end
      else if (req_kind_i == IAD_MEM && req_inbound_i)
      begin
         // RULE15 RULE19 RULE20
         if (a >= gaddr(in_base) && a < gaddr(in_limit) + ONE_MB)
         begin
            next_dest = is_dram ? IAD_DST_DRAM : IAD_DST_ABORT; // RULE23
            next_nc = a >= gaddr(nc_base)
                      && a < gaddr(nc_limit) + ONE_MB; // RULE14
         end
         else if (port_hit)
         begin
            next_dest = IAD_DST_PORT;
            next_port = hit_port;
         end
         else
            next_dest = IAD_DST_HUB; // RULE10
      end
      else if (port_hit && req_kind_i == IAD_MEM)
      begin
         next_dest = IAD_DST_PORT;
         next_port = hit_port;
      end
      else
         next_dest = IAD_DST_HUB; // RULE10 RULE15 RULE19
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dec_valid_o  <= 1'b0;
         dec_dest_o   <= IAD_DST_NONE;
         dec_port_o   <= '0;
         dec_noncoh_o <= 1'b0;
         dec_lock_o   <= 1'b0;
         dec_addr_o   <= '0;
         cfg_bus_o    <= '0;
         cfg_dev_o    <= '0;
         cfg_func_o   <= '0;
      end
      else
      begin
         dec_valid_o  <= req_valid_i;
         dec_dest_o   <= req_valid_i ? next_dest : IAD_DST_NONE;
         dec_port_o   <= next_port;
         dec_noncoh_o <= next_nc;
         dec_lock_o   <= req_lock_i; // RULE22
         dec_addr_o   <= a;
         if (req_kind_i == IAD_MEM)
            dec_addr_o[63:40] <= '0; // RULE3
         if (req_kind_i == IAD_IO)
            dec_addr_o[31:16] <= '0; // RULE7
         cfg_bus_o  <= a[27:20]; // RULE8
         cfg_dev_o  <= a[19:15];
         cfg_func_o <= a[14:12];
      end
   end

   // sticky error flags, hardware set beats software clear
   logic [2:0] st_set;
   logic [2:0] st_clr;
   assign st_set = req_valid_i ? {ap_err, io_err, mem_err} : 3'h0;
   assign st_clr = (wr_go && aw_q == REG_STATUS && ws_q[0]) ? w_q[2:0]
                   : 3'h0;
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         status <= 3'h0;
      else
         status <= (status & ~st_clr) | st_set; // RULE25
   end

   mem_err_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      req_valid_i && mem_err |=> dec_dest_o == IAD_DST_ERR
      && status[ST_MEM_ERR]) else $error("memory error not flagged"); // RULE2
   io_err_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      req_valid_i && io_err |=> status[ST_IO_ERR])
      else $error("io error not flagged"); // RULE6
   hi_bits_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      dec_valid_o && dec_dest_o == IAD_DST_DRAM |-> dec_addr_o < EIGHT_GB)
      else $error("dram beyond 8 GB"); // RULE11
   mem_top_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $past(req_kind_i) == IAD_MEM |-> dec_addr_o[63:40] == 24'h0)
      else $error("memory bits 63..40 set"); // RULE3
   io_top_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $past(req_kind_i) == IAD_IO |-> dec_addr_o[31:16] == 16'h0)
      else $error("io bits 31..16 set"); // RULE7
   vga_fwd_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      req_valid_i && vga_hit && !mem_err && !io_err && !ap_err
      && vga_any |=> dec_dest_o == IAD_DST_PORT)
      else $error("vga not forwarded"); // RULE16
   sub_dec_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      req_valid_i && !req_inbound_i && req_kind_i == IAD_MEM && !vga_hit
      && !port_hit |=> dec_dest_o == IAD_DST_HUB)
      else $error("unmatched not subtractive"); // RULE10
   sticky_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      status[ST_MEM_ERR] && !st_clr[ST_MEM_ERR] |=> status[ST_MEM_ERR])
      else $error("status flag lost"); // RULE25
   hi_addr_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      req_valid_i && !req_inbound_i && |req_addr_i[63:36]
      |=> dec_addr_o[63:36] == 28'h0) else $error("link bits kept"); // RULE1
endmodule

//--- testbench/iad_far_end.sv
// far-end target model: takes every decoded delivery
`timescale 1ns/1ps
module iad_far_end
   import iad_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        valid_i,
   input  wire logic [2:0]  dest_i,
   output logic      [15:0] seen_o
);
   // targets never stall the decoder, so a pulse is one delivery
   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         seen_o <= 16'h0000;
      else if (valid_i && dest_i != IAD_DST_NONE)
         seen_o <= seen_o + 16'h0001;
   end
endmodule

//--- testbench/test_io_hub_address_decoder.sv
// self-checking bench for the i/o hub address decoder
`timescale 1ns/1ps
module test_io_hub_address_decoder
   import iad_pkg::*;
;
   typedef struct packed {
      logic        inb;
      logic [1:0]  kind;
      logic        wr;
      logic        lk;
      logic [2:0]  src;
      logic [63:0] addr;
      logic [2:0]  dest;
      logic [2:0]  port;
      logic        nc;
   } iad_row_t;
   logic        sys_clk_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o;
   logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
   logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
   logic        s_axi_rvalid_o, s_axi_rready_i, req_valid_i;
   logic        req_inbound_i, req_write_i, req_lock_i, dec_valid_o;
   logic        dec_noncoh_o, dec_lock_o;
   logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, cfg_bus_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, req_kind_i;
   logic [2:0]  req_src_port_i, dec_dest_o, dec_port_o, cfg_func_o;
   logic [63:0] req_addr_i, dec_addr_o;
   logic [4:0]  cfg_dev_o;
   logic [15:0] seen;
   int          miscompares, compares, sent;
   iad_row_t    rows [14];
   iad_row_t    r;
   iad_decoder iad_decoder_i (.*);
   iad_far_end iad_far_end_i (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .valid_i   (dec_valid_o),
      .dest_i    (dec_dest_o),
      .seen_o    (seen)
   );
   initial
   begin
      sys_clk_i = 1'h0;
      forever
         #5 sys_clk_i = ~sys_clk_i;
   end
   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic hang;
      miscompares++;
      $display("[ERR] %0t wait ran out", $time);
      conclude();
   endtask
   // a wait of twenty cycles is far beyond any legal answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      int n;
      @(posedge sys_clk_i);
      s_axi_awaddr_i  <= a;
      s_axi_wdata_i   <= d;
      s_axi_awvalid_i <= 1'h1;
      s_axi_wvalid_i  <= 1'h1;
      s_axi_bready_i  <= 1'h1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge sys_clk_i);
         if (s_axi_awready_o)
            s_axi_awvalid_i <= 1'h0;
         if (s_axi_wready_o)
            s_axi_wvalid_i <= 1'h0;
         if (s_axi_bvalid_o)
            break;
      end
      if (n == 20)
         hang();
      s_axi_bready_i <= 1'h0;
      chk(s_axi_bresp_o, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      int n;
      @(posedge sys_clk_i);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'h1;
      s_axi_rready_i  <= 1'h1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge sys_clk_i);
         if (s_axi_arready_o)
            s_axi_arvalid_i <= 1'h0;
         if (s_axi_rvalid_o)
            break;
      end
      if (n == 20)
         hang();
      s_axi_rready_i <= 1'h0;
      chk(s_axi_rdata_o, d);
      chk(s_axi_rresp_o, e);
   endtask
   task automatic drive(input iad_row_t t);
      req_valid_i    <= 1'h1;
      req_inbound_i  <= t.inb;
      req_kind_i     <= t.kind;
      req_write_i    <= t.wr;
      req_lock_i     <= t.lk;
      req_src_port_i <= t.src;
      req_addr_i     <= t.addr;
      sent++;
   endtask
   // a none destination in a row means the target is not checked
   task automatic chkrow(input iad_row_t t);
      chk(dec_valid_o, 1'h1);
      chk(dec_lock_o, t.lk);
      if (t.dest != IAD_DST_NONE)
         chk(dec_dest_o, t.dest);
      if (t.dest == IAD_DST_PORT && t.kind == 2'h0)
         chk(dec_port_o, t.port);
      if (t.dest == IAD_DST_DRAM)
         chk(dec_noncoh_o, t.nc);
   endtask
   task automatic one(input iad_row_t t);
      @(posedge sys_clk_i);
      drive(t);
      @(posedge sys_clk_i);
      req_valid_i <= 1'h0;
      #1;
      chkrow(t);
   endtask
   initial
   begin
      {arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
      {s_axi_arvalid_i, s_axi_rready_i, req_valid_i} = 3'h0;
      {req_inbound_i, req_write_i, req_lock_i, req_kind_i} = 5'h00;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
      {req_src_port_i, req_addr_i} = 67'h0;
      s_axi_wstrb_i = 4'hF;
      rows = '{
         '{1'h0,2'h0,1'h0,1'h0,3'h0,64'h0_C000_1000,3'h2,3'h0,1'h0},
         '{1'h0,2'h0,1'h0,1'h0,3'h0,64'h10_C000_1000,3'h3,3'h0,1'h0},
         '{1'h0,2'h0,1'h1,1'h0,3'h0,64'h000A_0000,3'h2,3'h2,1'h0},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h000B_FFFF,3'h2,3'h2,1'h0},
         '{1'h0,2'h0,1'h0,1'h0,3'h0,64'h0012_3456,3'h3,3'h0,1'h0},
         '{1'h0,2'h0,1'h0,1'h0,3'h0,64'h000E_0000,3'h3,3'h0,1'h0},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h000F_0000,3'h1,3'h0,1'h0},
         '{1'h1,2'h0,1'h1,1'h0,3'h7,64'h0100_0000,3'h1,3'h0,1'h1},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h1_0000_0000_0000,3'h5,3'h0,1'h0},
         '{1'h1,2'h1,1'h0,1'h0,3'h7,64'h0001_0000,3'h5,3'h0,1'h0},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h5000_0000,3'h4,3'h0,1'h0},
         '{1'h0,2'h0,1'h1,1'h1,3'h0,64'h000C_0000,3'h3,3'h0,1'h0},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h0,3'h1,3'h0,1'h0},
         '{1'h1,2'h0,1'h0,1'h0,3'h7,64'h1_0000_0000,3'h5,3'h0,1'h0}
      };
      repeat (2) @(posedge sys_clk_i);
      chk(dec_dest_o, 3'h0);
      arst_n_i <= 1'h1;
      rd(REG_LOW_TOP, 32'h0, AXI_OKAY);
      rd(REG_POP_TOP - 8'h04, 32'h0, AXI_OKAY);
      rd(8'hFC, 32'h0, AXI_SLVERR);
      wr(8'hFC, 32'hFFFF_FFFF, AXI_SLVERR);
      wr(REG_LOW_TOP, 32'h0400, AXI_OKAY);
      wr(REG_HIGH_TOP, 32'h3000, AXI_OKAY);
      wr(REG_NC_BASE, 32'h0010, AXI_OKAY);
      wr(REG_NC_LIMIT, 32'h001F, AXI_OKAY);
      wr(REG_IN_LIMIT, 32'h07FF, AXI_OKAY);
      wr(REG_POP_TOP, 32'h0400, AXI_OKAY);
      rd(REG_POP_TOP, 32'h0400, AXI_OKAY);
      wr(REG_POP_TOP, 32'h0FFF, AXI_OKAY);
      wr(REG_PBASE0, 32'h0C00, AXI_OKAY);
      wr(REG_PLIM0, 32'h0C0F, AXI_OKAY);
      wr(REG_VGA_EN, 32'h4, AXI_OKAY);
      wr(REG_AP_BASE, 32'h0D00, AXI_OKAY);
      wr(REG_AP_LIMIT, 32'h0D0F, AXI_OKAY);
      rd(REG_LOW_TOP, 32'h0400, AXI_OKAY);
      for (int i = 0; i < 14; i++)
      begin
         @(posedge sys_clk_i);
         drive(rows[i]);
         #1;
         if (i > 0)
            chkrow(rows[i - 1]);
      end
      @(posedge sys_clk_i);
      req_valid_i <= 1'h0;
      #1;
      chkrow(rows[13]);
      rd(REG_STATUS, 32'h3, AXI_OKAY);
      wr(REG_STATUS, 32'h3, AXI_OKAY);
      rd(REG_STATUS, 32'h0, AXI_OKAY);
      r = '{1'h0,2'h1,1'h0,1'h0,3'h0,64'hFFFF_0CF8,3'h3,3'h0,1'h0};
      one(r);
      chk(dec_addr_o, 64'h0CF8);
      r = '{1'h0,2'h2,1'h0,1'h0,3'h0,64'h0FFF_F000,3'h2,3'h0,1'h0};
      one(r);
      chk({cfg_bus_o, cfg_dev_o, cfg_func_o}, 16'hFFFF);
      wr(REG_CTRL, 32'h1, AXI_OKAY);
      r = '{1'h0,2'h0,1'h0,1'h0,3'h0,64'hF_C012_3456,3'h3,3'h0,1'h0};
      one(r);
      chk(dec_addr_o, 64'h0012_3456);
      wr(REG_CTRL, 32'h2, AXI_OKAY);
      r = '{1'h1,2'h0,1'h1,1'h0,3'h7,64'hD000_0000,3'h0,3'h0,1'h0};
      one(r);
      rd(REG_STATUS, 32'h0, AXI_OKAY);
      r = '{1'h1,2'h0,1'h0,1'h0,3'h0,64'hD000_0000,3'h5,3'h0,1'h0};
      one(r);
      rd(REG_STATUS, 32'h4, AXI_OKAY);
      @(posedge sys_clk_i);
      #1;
      chk(seen, 16'(sent));
      // mid-run reset must clear outputs and registers
      @(posedge sys_clk_i);
      arst_n_i <= 1'h0;
      @(posedge sys_clk_i);
      chk({dec_valid_o, dec_dest_o, s_axi_bvalid_o, s_axi_rvalid_o}, 6'h0);
      arst_n_i <= 1'h1;
      rd(REG_LOW_TOP, 32'h0, AXI_OKAY);
      rd(REG_STATUS, 32'h0, AXI_OKAY);
      conclude();
   end
endmodule
